// *** common/ubt_pkg.sv ***
/*
 Shared constants and types for the baud timing and configuration block.
 Assumes a single clock domain and a simple strobe-based register port.
*/
package ubt_pkg;

	// Register byte offsets
	localparam logic [7:0] UBT_BRGR_OFS = 8'h00;
	localparam logic [7:0] UBT_RTOR_OFS = 8'h04;
	localparam logic [7:0] UBT_TTGR_OFS = 8'h08;
	localparam logic [7:0] UBT_FIDI_OFS = 8'h0C;
	localparam logic [7:0] UBT_NER_OFS = 8'h10;
	localparam logic [7:0] UBT_IF_OFS = 8'h14;
	localparam logic [7:0] UBT_MODE_OFS = 8'h18;
	localparam logic [7:0] UBT_STAT_OFS = 8'h1C;
	localparam logic [7:0] UBT_CMD_OFS = 8'h20;

	// Field positions
	localparam int UBT_FP_LSB = 16;
	localparam int UBT_FP_MSB = 18;
	localparam int UBT_MODE_SYNC_BIT = 0;
	localparam int UBT_MODE_OVER_BIT = 1;
	localparam int UBT_MODE_ISO_BIT = 2;
	localparam int UBT_STAT_TO_BIT = 0;
	localparam int UBT_STAT_GUARD_BIT = 1;
	localparam int UBT_CMD_STTO_BIT = 0;

	// Reset values
	localparam logic [10:0] UBT_RATIO_RST = 11'h174;

	// Oversampling divisors
	localparam logic [10:0] UBT_DIV_ASYNC = 11'h010;
	localparam logic [10:0] UBT_DIV_OVER = 11'h008;
	localparam logic [10:0] UBT_DIV_SYNC = 11'h001;

	typedef enum logic [2:0] {
		UBT_TO_IDLE = 3'b001,
		UBT_TO_RUN = 3'b010,
		UBT_TO_DONE = 3'b100
	} ubt_to_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ubt_bus_s;

	typedef struct packed {
		logic [15:0] integer_divider;
		logic [2:0] fraction_eighths;
		logic sync_mode;
		logic over_mode;
		logic iso_mode;
		logic [15:0] timeout_bit_count;
		logic [7:0] guard_bit_count;
		logic [10:0] smartcard_rate_ratio;
		logic [7:0] error_total;
		logic [7:0] ir_filter;
		logic [15:0] div_cnt;
		logic [2:0] frac_acc;
		logic frac_ext;
		logic [10:0] sub_cnt;
		logic sample_tick;
		logic bit_tick;
		ubt_to_e to_st;
		logic [15:0] to_cnt;
		logic timeout_flag;
		logic [7:0] tg_cnt;
		logic [7:0] ir_cnt;
		logic ir_out;
		logic [31:0] rdata;
	} ubt_state_s;

endpackage

// *** verilog/ubt_core.sv ***
/*
 Baud divider, receiver time-out, transmit timeguard, smart-card error
 counter and infrared pulse filter of a serial transceiver.
 Assumes all inputs synchronous to clk; the selected clock is clk itself.
*/
`timescale 1ns/1ps

// Function
// - Divider zero stops baud clock entirely
// - Baud is clock over 16, 8 or 1 times divider
// - Smart-card baud is clock over divider over ratio
// - Zero fraction disables fractional divider
// - Fraction adds eighths to divider in asynchronous mode only
// - Zero time-out value disables time-out
// - Time-out lasts value times bit period
// - Zero timeguard adds no idle delay
// - Timeguard holds line idle value bit periods
// - Smart-card ratio zero yields no clock
// - Smart-card baud is serial clock over ratio
// - Count every smart-card transfer error; the count holds at 255
// - Reading error count clears it
// - Filter value configures infrared demodulator filter
// - Time-out flag sets after start command elapses
module ubt_core
	import ubt_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire ubt_bus_s bus,
	output logic [31:0] rdata,
	input wire logic tx_char_done,
	input wire logic sc_error,
	input wire logic ir_rx_in,
	output logic sck_tick,
	output logic bit_tick,
	output logic guard_active,
	output logic timeout_flag,
	output logic ir_rx_filt
);

	ubt_state_s s;
	ubt_state_s next_s;

	function automatic logic hit(input ubt_bus_s b, input logic [7:0] ofs);
		hit = (b.addr == ofs);
	endfunction

	function automatic logic [15:0] dec_sat(input logic [15:0] v);
		dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
	endfunction

	logic start_cmd;
	logic ner_read;
	logic samp;
	logic [2:0] frac_eff;
	logic [3:0] frac_sum;
	logic [10:0] sub_len;

	always_comb begin
		next_s = s;
		next_s.rdata = 32'h0000_0000;
		start_cmd = bus.wr && hit(bus, UBT_CMD_OFS) && bus.wdata[UBT_CMD_STTO_BIT];
		ner_read = bus.rd && hit(bus, UBT_NER_OFS);
		samp = 1'b0;
		frac_sum = 4'h0;

		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				UBT_BRGR_OFS: begin
					next_s.integer_divider = bus.wdata[15:0];
					next_s.fraction_eighths = bus.wdata[UBT_FP_MSB:UBT_FP_LSB];
				end
				UBT_RTOR_OFS: next_s.timeout_bit_count = bus.wdata[15:0];
				UBT_TTGR_OFS: next_s.guard_bit_count = bus.wdata[7:0];
				UBT_FIDI_OFS: next_s.smartcard_rate_ratio = bus.wdata[10:0];
				UBT_IF_OFS: next_s.ir_filter = bus.wdata[7:0];
				UBT_MODE_OFS: begin
					next_s.sync_mode = bus.wdata[UBT_MODE_SYNC_BIT];
					next_s.over_mode = bus.wdata[UBT_MODE_OVER_BIT];
					next_s.iso_mode = bus.wdata[UBT_MODE_ISO_BIT];
				end
				default: ;
			endcase
		end

		// Register reads, answered the next cycle
		if (bus.rd) begin
			case (bus.addr)
				UBT_BRGR_OFS: begin
					next_s.rdata[15:0] = s.integer_divider;
					next_s.rdata[UBT_FP_MSB:UBT_FP_LSB] = s.fraction_eighths;
				end
				UBT_RTOR_OFS: next_s.rdata[15:0] = s.timeout_bit_count;
				UBT_TTGR_OFS: next_s.rdata[7:0] = s.guard_bit_count;
				UBT_FIDI_OFS: next_s.rdata[10:0] = s.smartcard_rate_ratio;
				UBT_NER_OFS: next_s.rdata[7:0] = s.error_total;
				UBT_IF_OFS: next_s.rdata[7:0] = s.ir_filter;
				UBT_MODE_OFS: begin
					next_s.rdata[UBT_MODE_SYNC_BIT] = s.sync_mode;
					next_s.rdata[UBT_MODE_OVER_BIT] = s.over_mode;
					next_s.rdata[UBT_MODE_ISO_BIT] = s.iso_mode;
				end
				UBT_STAT_OFS: begin
					next_s.rdata[UBT_STAT_TO_BIT] = s.timeout_flag;
					next_s.rdata[UBT_STAT_GUARD_BIT] = (s.tg_cnt != 8'h00);
				end
				default: ;
			endcase
		end

		// Fraction only applies to asynchronous framing
		frac_eff = (s.sync_mode || s.iso_mode) ? 3'h0 : s.fraction_eighths;

		// Divider stage: one sample tick per divider + fraction/8 clocks
		// Ratio zero in smart-card mode silences the serial clock too
		if (s.integer_divider == 16'h0000 ||
			(s.iso_mode && s.smartcard_rate_ratio == 11'h000)) begin
			next_s.div_cnt = 16'h0000;
			next_s.frac_ext = 1'b0;
			next_s.sub_cnt = 11'h000;
		end else if (s.frac_ext) begin
			next_s.frac_ext = 1'b0;
			next_s.div_cnt = 16'h0000;
			samp = 1'b1;
		end else if (s.div_cnt >= s.integer_divider - 16'h0001) begin
			next_s.div_cnt = 16'h0000;
			frac_sum = {1'b0, s.frac_acc} + {1'b0, frac_eff};
			next_s.frac_acc = frac_sum[2:0];
			// Carry stretches this period by one clock
			if (frac_sum[3]) begin
				next_s.frac_ext = 1'b1;
			end else begin
				samp = 1'b1;
			end
		end else begin
			next_s.div_cnt = s.div_cnt + 16'h0001;
		end

		// Bit stage: sample ticks per bit
		if (s.iso_mode) begin
			sub_len = s.smartcard_rate_ratio;
		end else if (s.sync_mode) begin
			sub_len = UBT_DIV_SYNC;
		end else if (s.over_mode) begin
			sub_len = UBT_DIV_OVER;
		end else begin
			sub_len = UBT_DIV_ASYNC;
		end

		next_s.sample_tick = samp;
		next_s.bit_tick = 1'b0;
		if (sub_len == 11'h000) begin
			next_s.sub_cnt = 11'h000;
		end else if (samp) begin
			if (s.sub_cnt >= sub_len - 11'h001) begin
				next_s.sub_cnt = 11'h000;
				next_s.bit_tick = 1'b1;
			end else begin
				next_s.sub_cnt = s.sub_cnt + 11'h001;
			end
		end

		// Time-out: restart first, so an expiry in the same cycle wins
		if (start_cmd) begin
			next_s.timeout_flag = 1'b0;
			next_s.to_cnt = s.timeout_bit_count;
			next_s.to_st = UBT_TO_RUN;
		end
		case (s.to_st)
			UBT_TO_IDLE: ;
			UBT_TO_RUN: begin
				if (s.bit_tick) begin
					if (s.to_cnt <= 16'h0001) begin
						next_s.to_st = UBT_TO_DONE;
						next_s.timeout_flag = 1'b1;
					end else begin
						next_s.to_cnt = dec_sat(s.to_cnt);
					end
				end
			end
			UBT_TO_DONE: ;
			default: next_s.to_st = UBT_TO_IDLE;
		endcase
		if (s.timeout_bit_count == 16'h0000) begin
			next_s.to_st = UBT_TO_IDLE;
			next_s.timeout_flag = 1'b0;
		end

		// Timeguard after each transmitted character
		if (tx_char_done) begin
			next_s.tg_cnt = s.guard_bit_count;
		end else if (s.bit_tick) begin
			next_s.tg_cnt = (s.tg_cnt == 8'h00) ? 8'h00 : s.tg_cnt - 8'h01;
		end

		// Error counter; a new error in the read cycle is kept
		if (ner_read) begin
			next_s.error_total = 8'h00;
		end
		if (sc_error && s.iso_mode) begin
			if (ner_read) begin
				next_s.error_total = 8'h01;
			end else if (s.error_total != 8'hFF) begin
				next_s.error_total = s.error_total + 8'h01;
			end
		end

		// Infrared filter: input must differ for filter+1 clocks
		if (ir_rx_in == s.ir_out) begin
			next_s.ir_cnt = 8'h00;
		end else if (s.ir_cnt >= s.ir_filter) begin
			next_s.ir_out = ir_rx_in;
			next_s.ir_cnt = 8'h00;
		end else begin
			next_s.ir_cnt = s.ir_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.smartcard_rate_ratio <= UBT_RATIO_RST;
			s.to_st <= UBT_TO_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign sck_tick = s.sample_tick;
	assign bit_tick = s.bit_tick;
	assign guard_active = (s.tg_cnt != 8'h00);
	assign timeout_flag = s.timeout_flag;
	assign ir_rx_filt = s.ir_out;

endmodule

// *** bench/ubt_core_asserts.sv ***
/* Port checker for ubt_core.
 Assumes one clock domain; bound to every ubt_core below. */
`timescale 1ns/1ps
module ubt_chk
	import ubt_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire ubt_bus_s bus,
	input wire logic [31:0] rdata,
	input wire logic tx_char_done,
	input wire logic sc_error,
	input wire logic ir_rx_in,
	input wire logic sck_tick,
	input wire logic bit_tick,
	input wire logic guard_active,
	input wire logic timeout_flag,
	input wire logic ir_rx_filt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_clr; bus.rd && bus.addr == UBT_NER_OFS && !sc_error ##1
		bus.rd && bus.addr == UBT_NER_OFS |=> rdata == 32'h0; endproperty
	a_clr: assert property (p_clr) else $error("count kept");
	property p_sat; $past(bus.rd) && $past(bus.addr) == UBT_NER_OFS
		|-> rdata[31:8] == 24'h0; endproperty
	a_sat: assert property (p_sat) else $error("count wide");
	property p_tos; $rose(timeout_flag) |-> bit_tick || $past(bit_tick); endproperty
	a_tos: assert property (p_tos) else $error("flag off tick");
	property p_toc; $fell(timeout_flag) |-> $past(bus.wr); endproperty
	a_toc: assert property (p_toc) else $error("flag dropped");
	property p_tgs; $rose(guard_active) |-> $past(tx_char_done); endproperty
	a_tgs: assert property (p_tgs) else $error("guard start");
	property p_tgc; $fell(guard_active) |-> bit_tick || $past(bit_tick)
		|| $past(tx_char_done); endproperty
	a_tgc: assert property (p_tgc) else $error("guard end");
	property p_ir; $changed(ir_rx_filt) |-> $past(ir_rx_in) == ir_rx_filt; endproperty
	a_ir: assert property (p_ir) else $error("filter");
	property p_bit; bit_tick |-> sck_tick || $past(sck_tick); endproperty
	a_bit: assert property (p_bit) else $error("bit tick");
endmodule
bind ubt_core ubt_chk u_chk (.clk, .arst_n, .bus, .rdata, .tx_char_done, .sc_error,
	.ir_rx_in, .sck_tick, .bit_tick, .guard_active, .timeout_flag, .ir_rx_filt);

// *** bench/ubt_peer.sv ***
/* Far-side model: smart-card error pulses and infrared pulses.
 Assumes go is a one-cycle request from the bench. */
`timescale 1ns/1ps
module ubt_peer
(
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] ir_len,
	input wire logic [3:0] err_n,
	output logic sc_error,
	output logic ir_rx_in
);
	logic [7:0] ir_c = 8'h00;
	logic [3:0] e_c = 4'h0;
	logic ph = 1'h0;
	// Gaps between errors, so each pulse counts once
	assign sc_error = ph && e_c != 4'h0;
	assign ir_rx_in = ir_c != 8'h00;
	always_ff @(posedge clk) begin
		ph <= !ph;
		ir_c <= go ? ir_len : ir_c - {7'h0, ir_rx_in};
		e_c <= go ? err_n : e_c - {3'h0, sc_error};
	end
endmodule

// *** bench/tb_usart_baud_timing_config.sv ***
/* Bench for ubt_core with the peer model.
 Assumes ubt_pkg offsets and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("Error %0t: %0h not %0h", $time, a, b); end end
module tb_usart_baud_timing_config
	import ubt_pkg::*;
;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	ubt_bus_s bus = '0;
	logic tx_char_done = 1'h0;
	logic go = 1'h0;
	logic [7:0] ir_len = 8'h00;
	logic [3:0] err_n = 4'h0;
	logic [31:0] rdata;
	logic sc_error, ir_rx_in, sck_tick, bit_tick, guard_active, timeout_flag, ir_rx_filt;
	int err_count = 0;
	int n_tests = 0;
	always #10 clk = ~clk;
	ubt_core i_dut (.clk, .arst_n, .bus, .rdata, .tx_char_done, .sc_error, .ir_rx_in,
		.sck_tick, .bit_tick, .guard_active, .timeout_flag, .ir_rx_filt);
	ubt_peer i_peer (.clk, .go, .ir_len, .err_n, .sc_error, .ir_rx_in);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'h1, 1'h0};
		@(posedge clk) bus <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus <= '{a, 32'h0, 1'h0, 1'h1};
		@(posedge clk) bus <= '0;
		#1 `CHK(rdata, e)
	endtask
	// First tick may be a leftover of the old setting, so time the second
	task automatic gap(input int e);
		int n;
		repeat (2) begin
			n = 0;
			do
				@(posedge clk) #1 n++;
			while (bit_tick !== 1'h1 && n < 3000);
		end
		`CHK(n, e)
	endtask
	task automatic quiet();
		logic s;
		s = 1'h0;
		repeat (99) @(posedge clk) #1 s |= sck_tick | bit_tick;
		`CHK(s, 1'h0)
	endtask
	task automatic t_rate();
		wr(UBT_BRGR_OFS, 32'h3);
		gap(48);
		wr(UBT_MODE_OFS, 32'h2);
		gap(24);
		wr(UBT_MODE_OFS, 32'h1);
		gap(3);
		wr(UBT_FIDI_OFS, 32'h5);
		wr(UBT_MODE_OFS, 32'h4);
		gap(15);
		wr(UBT_MODE_OFS, 32'h0);
		wr(UBT_BRGR_OFS, 32'h40003);
		gap(56);
		wr(UBT_BRGR_OFS, 32'h0);
		quiet();
		wr(UBT_BRGR_OFS, 32'h3);
		wr(UBT_MODE_OFS, 32'h4);
		wr(UBT_FIDI_OFS, 32'h0);
		quiet();
		$display("rate done");
	endtask
	task automatic t_to();
		int n;
		n = 0;
		wr(UBT_MODE_OFS, 32'h1);
		wr(UBT_RTOR_OFS, 32'h4);
		wr(UBT_CMD_OFS, 32'h1);
		while (timeout_flag !== 1'h1 && n < 99) @(posedge clk) #1 n++;
		`CHK(n >= 9 && n <= 16, 1'h1)
		wr(UBT_RTOR_OFS, 32'h0);
		wr(UBT_CMD_OFS, 32'h1);
		repeat (30) @(posedge clk) #1;
		`CHK(timeout_flag, 1'h0)
		$display("timeout done");
	endtask
	task automatic t_guard(input logic [7:0] g, input int lo, input int hi);
		int n;
		n = 0;
		wr(UBT_TTGR_OFS, {24'h0, g});
		tx_char_done <= 1'h1;
		@(posedge clk) tx_char_done <= 1'h0;
		repeat (40) @(posedge clk) #1 n += guard_active;
		`CHK(n >= lo && n <= hi, 1'h1)
		$display("guard done");
	endtask
	task automatic t_peer(input logic [3:0] e, input logic [7:0] l, input logic f);
		logic s;
		s = 1'h0;
		err_n <= e;
		ir_len <= l;
		go <= 1'h1;
		@(posedge clk) go <= 1'h0;
		repeat (30) @(posedge clk) #1 s |= ir_rx_filt;
		`CHK(s, f)
		rd(UBT_NER_OFS, {28'h0, e});
		$display("peer done");
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk) #1;
		rd(UBT_FIDI_OFS, 32'h174);
		rd(8'h30, 32'h0);
		t_rate();
		t_to();
		t_guard(8'h2, 3, 8);
		t_guard(8'h0, 0, 0);
		wr(UBT_FIDI_OFS, 32'h5);
		wr(UBT_MODE_OFS, 32'h4);
		wr(UBT_IF_OFS, 32'h3);
		t_peer(4'h3, 8'h3, 1'h0);
		t_peer(4'h2, 8'h8, 1'h1);
		rd(UBT_NER_OFS, 32'h0);
		tally_and_finish();
	end
	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end
endmodule
